// ### rtl/radio_mode_control.sv
// Mode control register with its data rate and lock count companions.
//
// Function
// - Bit 7 set enables receive mode.
// - Bit 6 set enables transmit mode.
// - Bit 5 picks upper or lower code half.
// - Half select only acts in 32-chip mode.
// - Settle delay is lock count times 2 us.
// - Bit 4 skips waiting for synthesizer lock.
// - Bit 3 chooses register or automatic amplifier control.
// - Register control: bit 2 drives amplifier enable.
// - Registers read and write.
`timescale 1ns/100ps
`include "radio_mode_defs.svh"
module radio_mode_control #(
    parameter int UNIT_CYCLES = `LOCK_UNIT_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  regAddr,
    input  wire logic [7:0]  regWriteData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic        synthLocked,
    input  wire logic        basebandAmpEnable,
    input  wire logic [63:0] spreadCode,
    output logic [7:0]       regReadData,
    output logic             receiveMode,
    output logic             transmitMode,
    output logic [31:0]      activeCodeHalf,
    output logic             codeWidth32,
    output logic             amp_enable,
    output logic             synthSettled
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] modeControl;
    logic [7:0] dataRate;
    logic [7:0] lockCount;
    logic       settledRaw;
    logic       settleStart;

    // Address match, shared by the write enables and the read mux.
    // One function keeps the three compares identical in width and form.
    function automatic logic addrIs(input logic [5:0] addr,
                                    input logic [5:0] target);
        addrIs = (addr == target);
    endfunction

    // Address decode for the three locally held registers.
    wire hitMode = addrIs(regAddr, `MODE_CONTROL_ADDR);
    wire hitRate = addrIs(regAddr, `DATA_RATE_ADDR);
    wire hitLock = addrIs(regAddr, `LOCK_COUNT_ADDR);

    // Per-register write enables; a write to any other address is
    // dropped here, since those registers live in other blocks.
    wire writeMode = regWrite && hitMode;
    wire writeRate = regWrite && hitRate;
    wire writeLock = regWrite && hitLock;

    // Field views of the mode control register.
    wire rxEnable                = modeControl[`RX_ENABLE_BIT];
    wire txEnable                = modeControl[`TX_ENABLE_BIT];
    wire spread_code_half_select = modeControl[`CODE_HALF_BIT];
    wire lockBypass              = modeControl[`LOCK_BYPASS_BIT];
    wire amp_control_source      = modeControl[`AMP_SOURCE_BIT];
    wire ampRegEnable            = modeControl[`AMP_ENABLE_BIT];

    // Field view of the data rate register: set means 32 chips per bit.
    wire wide32 = dataRate[`CODE_WIDTH_BIT];

    // Reserved low bits are masked before they reach the register.
    wire [7:0] writeModeValue = regWriteData & `MODE_WRITE_MASK;

    // A write that turns either path on restarts the synthesizer settle.
    // A write that leaves both paths as they were does not, so the host
    // can change the amplifier or code bits without losing settle time.
    wire modeTurnsOn = writeMode &&
        ((writeModeValue[`RX_ENABLE_BIT] && !rxEnable) ||
         (writeModeValue[`TX_ENABLE_BIT] && !txEnable));
    assign settleStart = modeTurnsOn;

    // The sequencer starts on the write edge itself, before the register
    // holds the new byte, so it is shown the bypass bit being written.
    // Taking the held bit instead would follow the previous mode.
    wire bypassNow = writeMode ? writeModeValue[`LOCK_BYPASS_BIT]
                               : lockBypass;

    // Code half: only in 32-chip mode does bit 5 steer it; else the low
    // half is presented so downstream sees a stable default.
    wire [31:0] next_codeHalf = (wide32 && spread_code_half_select) ?
        spreadCode[63:32] : spreadCode[31:0];

    // Amplifier enable source select. Under automatic control the
    // baseband level passes through one flop, so it lags by one cycle.
    wire next_ampEnable = amp_control_source ?
        ampRegEnable : basebandAmpEnable;

    // Read mux; unmapped addresses return zero since other registers
    // live in other blocks. Reads have no side effects here.
    wire [7:0] next_readData = hitMode ? modeControl :
                               hitRate ? dataRate    :
                               hitLock ? lockCount   : 8'h00;

    // Only a settled sequencer with a path enabled reports settled, so a
    // stale result from before both paths were turned off cannot leak.
    wire next_settled = settledRaw && (rxEnable || txEnable);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Mode control byte; the reserved bits arrive already masked.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeControl <= `MODE_CONTROL_RESET;
        end else if (writeMode) begin
            modeControl <= writeModeValue;
        end
    end

    // Data rate byte; only the code width bit is used here, but the whole
    // byte is kept so the host reads back what it wrote.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataRate <= `DATA_RATE_RESET;
        end else if (writeRate) begin
            dataRate <= regWriteData;
        end
    end

    // Lock count byte in 2 us units. A change while the sequencer waits
    // takes effect at once, since the count is compared, not loaded.
    // Lowering it below the steps already done ends the wait at once.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockCount <= `LOCK_COUNT_RESET;
        end else if (writeLock) begin
            lockCount <= regWriteData;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Read data stands for the one cycle after a read and is zero
    // otherwise, so a host sampling late sees zero rather than old data.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regReadData <= 8'h00;
        end else begin
            regReadData <= regRead ? next_readData : 8'h00;
        end
    end

    // Path enables follow the register one cycle behind it. The receive
    // and transmit bits are independent; both set is passed on unchanged.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            receiveMode  <= 1'b0;
            transmitMode <= 1'b0;
        end else begin
            receiveMode  <= rxEnable;
            transmitMode <= txEnable;
        end
    end

    // Spreading code half and the code width it depends on. The width
    // bit is exported so the correlators can agree with the half chosen.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeCodeHalf <= 32'h00000000;
            codeWidth32    <= 1'b0;
        end else begin
            activeCodeHalf <= next_codeHalf;
            codeWidth32    <= wide32;
        end
    end

    // Amplifier enable from whichever source bit 3 selects. The register
    // enable bit is kept while automatic control is chosen, so switching
    // back restores the last written enable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_enable <= 1'b0;
        end else begin
            amp_enable <= next_ampEnable;
        end
    end

    // Settled flag, gated by the path enables. It drops one cycle after
    // both paths are turned off, and a restart clears it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            synthSettled <= 1'b0;
        end else begin
            synthSettled <= next_settled;
        end
    end

    // ----------------------------------------------------------------
    // Synthesizer settle sequencer
    // ----------------------------------------------------------------
    // The sequencer restarts whenever a write turns a path on. With the
    // bypass bit set it counts straight away; with it clear it first waits
    // for the lock level. Either way the count is the lock count register
    // in 2 us units, so a count of zero settles right after the start or
    // the lock. A limitation: a lock level that drops during the count is
    // not watched again, as the count alone is trusted once lock was seen.
    settle_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) settleTimer (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .start       (settleStart),
        .lockBypass  (bypassNow),
        .synthLocked (synthLocked),
        .lockCount   (lockCount),
        .settled     (settledRaw)
    );
endmodule

// ### rtl/radio_mode_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef RADIO_MODE_DEFS_SVH
`define RADIO_MODE_DEFS_SVH

`define MODE_CONTROL_ADDR   6'h03
`define DATA_RATE_ADDR      6'h04
`define ANALOG_CONTROL_ADDR 6'h20
`define LOCK_COUNT_ADDR     6'h38

`define MODE_CONTROL_RESET  8'h00
`define DATA_RATE_RESET     8'h00
`define LOCK_COUNT_RESET    8'h64

`define RX_ENABLE_BIT       7
`define TX_ENABLE_BIT       6
`define CODE_HALF_BIT       5
`define LOCK_BYPASS_BIT     4
`define AMP_SOURCE_BIT      3
`define AMP_ENABLE_BIT      2
`define CODE_WIDTH_BIT      2
`define MODE_WRITE_MASK     8'hFC

`define CLK_PERIOD_NS       25
`define LOCK_UNIT_NS        2000
`define LOCK_UNIT_CYCLES    (`LOCK_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/radio_mode_pkg.sv
// Types shared by the mode control block.
package radio_mode_pkg;
    typedef enum logic [3:0] {
        SETTLE_IDLE = 4'b0001,
        SETTLE_LOCK = 4'b0010,
        SETTLE_WAIT = 4'b0100,
        SETTLE_DONE = 4'b1000
    } settle_state_t;
endpackage

// ### rtl/settle_timer.sv
// Synthesizer settle sequencer: optional lock wait, then count delay.
`timescale 1ns/100ps
`include "radio_mode_defs.svh"
module settle_timer #(
    parameter int UNIT_CYCLES = `LOCK_UNIT_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       lockBypass,
    input  wire logic       synthLocked,
    input  wire logic [7:0] lockCount,
    output logic            settled
);
    radio_mode_pkg::settle_state_t state;
    radio_mode_pkg::settle_state_t next_state;
    logic [15:0] unitCount;
    logic [7:0]  stepCount;
    logic        unitTick;
    logic        stepsDone;

    // One tick per 2 us unit of the lock count.
    assign unitTick  = (unitCount == 16'(UNIT_CYCLES - 1));
    assign stepsDone = (stepCount >= lockCount);

    // Next state; start always restarts so a write that turns a path on resettles.
    always_comb begin
        next_state = state;
        case (state)
            radio_mode_pkg::SETTLE_IDLE: begin
                if (start) begin
                    next_state = lockBypass ? radio_mode_pkg::SETTLE_WAIT
                                            : radio_mode_pkg::SETTLE_LOCK;
                end
            end
            radio_mode_pkg::SETTLE_LOCK: begin
                if (synthLocked) begin
                    next_state = radio_mode_pkg::SETTLE_WAIT;
                end
            end
            radio_mode_pkg::SETTLE_WAIT: begin
                if (stepsDone) begin
                    next_state = radio_mode_pkg::SETTLE_DONE;
                end
            end
            radio_mode_pkg::SETTLE_DONE: begin
                next_state = radio_mode_pkg::SETTLE_DONE;
            end
            default: begin
                next_state = radio_mode_pkg::SETTLE_IDLE;
            end
        endcase
        // A restart jumps straight into the new sequence; parking in idle
        // would wait for a second start that never comes.
        if (start) begin
            next_state = lockBypass ? radio_mode_pkg::SETTLE_WAIT
                                    : radio_mode_pkg::SETTLE_LOCK;
        end
    end

    // State and delay counters.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= radio_mode_pkg::SETTLE_IDLE;
            unitCount <= 16'h0000;
            stepCount <= 8'h00;
            settled   <= 1'b0;
        end else begin
            state   <= next_state;
            settled <= (next_state == radio_mode_pkg::SETTLE_DONE);
            if (state != radio_mode_pkg::SETTLE_WAIT || unitTick || start) begin
                unitCount <= 16'h0000;
            end else begin
                unitCount <= unitCount + 16'h0001;
            end
            if (state != radio_mode_pkg::SETTLE_WAIT || start) begin
                stepCount <= 8'h00;
            end else if (unitTick && !stepsDone) begin
                stepCount <= stepCount + 8'h01;
            end
        end
    end
endmodule

// ### test/radio_mode_control_asserts.sv
// Port checker for the mode control register.
`timescale 1ns/100ps
module radio_mode_control_asserts #(parameter int UNIT_CYCLES = 80) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [5:0]  regAddr,
    input wire logic [7:0]  regWriteData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic        synthLocked,
    input wire logic        basebandAmpEnable,
    input wire logic [63:0] spreadCode,
    input wire logic [7:0]  regReadData,
    input wire logic        receiveMode,
    input wire logic        transmitMode,
    input wire logic [31:0] activeCodeHalf,
    input wire logic        codeWidth32,
    input wire logic        amp_enable,
    input wire logic        synthSettled
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // A mode write shows at the outputs two edges later.
    wire modeWr = regWrite && regAddr == 6'h03;
    a_rx_follow: assert property (
        modeWr |-> ##2 receiveMode == $past(regWriteData[7], 2)) else $error("rx");
    a_tx_follow: assert property (
        modeWr |-> ##2 transmitMode == $past(regWriteData[6], 2)) else $error("tx");
    a_amp_reg: assert property (
        modeWr && regWriteData[3] |-> ##2 amp_enable == $past(regWriteData[2], 2))
        else $error("amp register");
    a_amp_auto: assert property (
        modeWr && !regWriteData[3] |-> ##2 amp_enable == $past(basebandAmpEnable))
        else $error("amp automatic");
    a_mode_readback: assert property (
        modeWr ##1 (regRead && !regWrite && regAddr == 6'h03)
        |=> regReadData == ($past(regWriteData, 2) & 8'hFC)) else $error("rb");
    a_read_idle: assert property (
        !regRead |=> regReadData == 8'h00) else $error("idle read data");
    a_code_half: assert property (
        modeWr |-> ##2 activeCodeHalf == ((codeWidth32 && $past(regWriteData[5], 2))
        ? $past(spreadCode[63:32]) : $past(spreadCode[31:0]))) else $error("half");
    a_settle_off: assert property (
        (!receiveMode && !transmitMode)[*2] |-> !synthSettled) else $error("off");
    c_both: cover property (receiveMode && transmitMode);
    c_bypass: cover property (synthSettled && !synthLocked);
    c_amp: cover property (codeWidth32 && amp_enable);
endmodule
bind radio_mode_control radio_mode_control_asserts #(.UNIT_CYCLES(UNIT_CYCLES))
    chk (.ref_clk, .rst_n, .regAddr, .regWriteData, .regWrite, .regRead,
    .synthLocked, .basebandAmpEnable, .spreadCode, .regReadData, .receiveMode,
    .transmitMode, .activeCodeHalf, .codeWidth32, .amp_enable, .synthSettled);

// ### test/host_model.sv
// Host model that issues register accesses on the register port.
`timescale 1ns/100ps
module host_model (
    input  wire logic ref_clk,
    output logic [5:0] regAddr,
    output logic [7:0] regWriteData,
    output logic       regWrite,
    output logic       regRead
);
    initial {regAddr, regWriteData, regWrite, regRead} = '0;
    // One access per edge; callers chain these for back-to-back traffic.
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        {regAddr, regWriteData, regWrite, regRead} = {a, d, w, !w};
        @(posedge ref_clk) #1;
    endtask
    // Released lines are scrambled so stale data cannot pass for valid.
    task automatic idle();
        {regAddr, regWriteData, regWrite, regRead} = {~regAddr, ~regWriteData, 2'b00};
        @(posedge ref_clk) #1;
    endtask
endmodule

// ### test/test_radio_mode_control.sv
// Self-checking bench for the mode control register.
`timescale 1ns/100ps
module test_radio_mode_control;
    logic        ref_clk = 0, rst_n = 0, synthLocked = 0, basebandAmpEnable = 0;
    logic [63:0] spreadCode = '0;
    logic [5:0]  regAddr;
    logic [7:0]  regWriteData, regReadData, d, cw, expQ[$];
    logic        regWrite, regRead, receiveMode, transmitMode, codeWidth32;
    logic        amp_enable, synthSettled, lastRd = 0;
    logic [31:0] activeCodeHalf;
    int          err_total = 0, compares = 0, cyc = 0, n;
    initial forever #12.5 ref_clk = ~ref_clk;
    host_model host (.ref_clk(ref_clk), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead));
    radio_mode_control #(.UNIT_CYCLES(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .synthLocked(synthLocked),
        .basebandAmpEnable(basebandAmpEnable), .spreadCode(spreadCode),
        .regReadData(regReadData), .receiveMode(receiveMode),
        .transmitMode(transmitMode), .activeCodeHalf(activeCodeHalf),
        .codeWidth32(codeWidth32), .amp_enable(amp_enable),
        .synthSettled(synthSettled));
    task automatic check(input logic ok, input string msg);
        compares++;
        if (!ok) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.acc(1'b0, a, 8'h00);
    endtask
    task automatic settle_time(output int k);
        for (k = 0; k < 200 && synthSettled !== 1'b1; k++) @(posedge ref_clk) #1;
    endtask
    // Read data answers one cycle late, so the watcher looks a cycle behind.
    always @(negedge ref_clk) begin
        if (lastRd) check(regReadData === expQ.pop_front(), "read data");
        lastRd = regRead;
    end
    // Cycle ceiling cuts a hang short; a normal run needs about 150.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h7A20));
        repeat (10) @(posedge ref_clk);
        #1 rst_n = 1;
        rd(6'h03, 8'h00);
        rd(6'h38, 8'h64);
        rd(6'h3F, 8'h00);
        host.idle();
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            spreadCode = {$urandom, $urandom};
            basebandAmpEnable = 1'($urandom);
            d = 8'($urandom);
            cw = 8'($urandom);
            host.acc(1'b1, 6'h04, cw);
            host.acc(1'b1, 6'h03, d);
            rd(6'h03, d & 8'hFC);
            rd(6'h04, cw);
            host.idle();
            check(receiveMode === d[7], "rx");
            check(transmitMode === d[6], "tx");
            check(amp_enable === (d[3] ? d[2] : basebandAmpEnable),
                "amp");
            check(codeWidth32 === cw[2], "code width");
            check(activeCodeHalf === ((cw[2] && d[5]) ? spreadCode[63:32]
                : spreadCode[31:0]), "code half");
        end
        $display("random mode writes done");
        host.acc(1'b1, 6'h03, 8'h00);
        host.acc(1'b1, 6'h38, 8'h03);
        host.acc(1'b1, 6'h03, 8'h90);
        host.idle();
        settle_time(n);
        check(n >= 5 && n <= 12, "bypass settle");
        host.acc(1'b1, 6'h03, 8'h00);
        host.acc(1'b1, 6'h38, 8'h19);
        rd(6'h38, 8'h19);
        host.acc(1'b1, 6'h03, 8'h40);
        host.idle();
        repeat (20) @(posedge ref_clk);
        #1 check(synthSettled === 1'b0, "lock wait");
        synthLocked = 1;
        settle_time(n);
        check(n >= 48 && n <= 56, "lock settle");
        $display("settle tests done");
        finish_test();
    end
endmodule
